// File: mcd_pkg.sv
// constants and types shared by the motor command decoder
package mcd_pkg;
   // ==============================================================
   // command codes carried in frame byte 1
   localparam logic [7:0] CMD_OTP = 8'h90;  // otp_program_cmd
   localparam logic [7:0] CMD_SETPOS = 8'h8B;  // set_target_cmd
   localparam logic [7:0] CMD_SOFT = 8'h8F;  // gentle_stop_cmd
   localparam logic [7:0] CMD_REF = 8'h88;  // reference_search_cmd
   localparam logic [7:0] CMD_MOTOR = 8'h89;  // motor_setup_cmd
   localparam logic [7:0] CMD_STAT1 = 8'h81;  // status_read_one
   localparam logic [7:0] CMD_STAT2 = 8'hFC;  // status_read_two
   localparam logic [7:0] CMD_HARD = 8'h85;  // immediate_stop_cmd
   localparam logic [7:0] FILL_BYTE = 8'hFF;  // filler bytes 2 and 3
   localparam logic [1:0] ADDR_PREFIX = 2'h3;  // top bits of address byte
   localparam logic [4:0] OTP_WORD_ADDR_PREFIX = 5'h1F;  // top bits of word-address byte
   // ==============================================================
   // byte positions inside a frame
   localparam logic [3:0] IDX_ADDR = 4'h0;
   localparam logic [3:0] IDX_CMD = 4'h1;
   localparam logic [3:0] IDX_FILL_A = 4'h2;
   localparam logic [3:0] IDX_FILL_B = 4'h3;
   localparam logic [3:0] IDX_P0 = 4'h4;
   localparam logic [3:0] IDX_P1 = 4'h5;
   localparam logic [3:0] IDX_P2 = 4'h6;
   localparam logic [3:0] IDX_P3 = 4'h7;
   localparam logic [3:0] IDX_P4 = 4'h8;
   localparam logic [3:0] IDX_MAX = 4'hF;
   // ==============================================================
   // register map (byte addresses) and reset values
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;  // rw: node address bits
   localparam logic [7:0] OFF_STATE = 8'h04;  // ro: block state
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;  // ro: sticky events
   localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;  // wo: write one to clear
   localparam logic [7:0] OFF_IRQ_EN = 8'h10;  // rw: interrupt enables
   localparam logic [7:0] OFF_POS = 8'h14;  // ro: target and actual position
   localparam logic [7:0] OFF_PROGRAMMED_ADDRESS_BIT = 8'h18;  // ro: otp word 3
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] OTP_RST = 8'h00;
   localparam logic [6:0] IRQ_RST = 7'h00;
   localparam logic [2:0] OTP_CUR_WORD = 3'h3;  // word holding current defaults
   // ==============================================================
   // event bit positions
   localparam int IRQ_N = 7;
   localparam int EV_OTP = 0;  // otp word burned
   localparam int EV_MOVE = 1;  // move started
   localparam int EV_REFUSED = 2;  // motion command ignored
   localparam int EV_SOFT = 3;  // soft stop issued
   localparam int EV_REFDONE = 4;  // reference search finished
   localparam int EV_DEADLOCK = 5;  // deadlock entered
   localparam int EV_FRAME = 6;  // malformed frame
   // ==============================================================
   typedef enum logic [1:0] {REF_IDLE, REF_FIRST, REF_SECOND} mcd_ref_t;
endpackage

// File: mcd_decoder.sv
// frame decoder and command execution of the motor command decoder
`timescale 1ns/100ps
// Contract
// - otp command burns word chosen by address
// - pattern ones set bits, never clear any
// - otp word 3 gives run/hold defaults
// - set-position moves to 16-bit target, high first
// - set-position ignored on any fault flag
// - soft stop decelerates to minimum then stops
// - soft stop on overheat or host command
// - shutdown after power-on until status read one
// - deadlock when first target equals actual position
// - reference search two moves, then zero position
// - status reads report faults and position
// - deadlock left by hard stop then status one
module mcd_decoder
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [mcd_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic o_irq,
   // received bytes from the serial bus receiver
   input wire logic i_rx_start,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   // pins from the analog side, asynchronous
   input wire logic i_hw_address_pin_bit,
   input wire logic i_thermal_shutdown_flag,
   input wire logic i_undervoltage_flag,
   input wire logic i_step_loss_flag,
   input wire logic i_electrical_defect_flag,
   // ramp generator
   input wire logic i_motion_active,
   input wire logic i_motion_done,
   input wire logic [15:0] i_actual_pos,
   output logic o_move_go,
   output logic [15:0] o_target_position,
   output logic o_soft_stop,
   output logic o_hard_stop,
   output logic o_pos_zero,
   // status transmitter and defaults
   output logic o_report_one,
   output logic o_report_two,
   output logic o_shutdown,
   output logic [3:0] o_run_current_dflt,
   output logic [3:0] o_hold_current_dflt
);
   import mcd_pkg::*;

   // ==============================================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_ff;  // release shifter
   logic rst_n;  // synchronised reset for the rest
   logic [4:0] pin_meta_ff;  // first stage, read only by second
   logic [4:0] pin_ff;  // second stage
   logic therm_d_ff;  // for overheat edge detection

   // async assert, clocked release
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // two flops on every analog pin
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_ff <= 5'h00;
         pin_ff <= 5'h00;
         therm_d_ff <= 1'b0;
      end
      else
      begin
         pin_meta_ff <= {i_hw_address_pin_bit, i_thermal_shutdown_flag,
                         i_undervoltage_flag, i_step_loss_flag,
                         i_electrical_defect_flag};
         pin_ff <= pin_meta_ff;
         therm_d_ff <= pin_ff[3];
      end
   end

   logic hw_bit;  // synchronised address pin
   logic fault;  // any blocking fault flag
   logic therm_rise;  // overheat just appeared
   assign hw_bit = pin_ff[4];
   assign fault = |pin_ff[3:0];
   assign therm_rise = pin_ff[3] && !therm_d_ff;

   // ==============================================================
   // frame decoding
   logic [3:0] node_addr_ff;  // programmed address bits, from software
   logic [3:0] idx_ff;  // position of the next byte
   logic mine_ff;  // frame still addressed to us and well formed
   logic [7:0] cmd_ff;  // command of the running frame
   logic [7:0] hold_ff;  // previous payload byte
   logic [2:0] otp_word_addr_ff;  // otp_word_addr
   logic [15:0] pos1_ff;  // first reference target
   logic ex_otp_ff, ex_pos_ff, ex_ref_ff;  // execution pulses
   logic ex_soft_ff, ex_hard_ff, ex_st1_ff, ex_st2_ff;
   logic bad_frame_ff;  // malformed frame pulse
   logic [7:0] pat_ff;  // otp bit pattern
   logic [15:0] tgt_ff;  // assembled target / second reference target
   logic take;  // byte accepted for decoding
   logic long_cmd;  // command that carries fillers

   // address byte we answer to
   function automatic logic [7:0] own_addr(input logic [3:0] node, input logic hw);
      own_addr = {ADDR_PREFIX, node, hw, 1'b0};
   endfunction

   assign take = i_rx_valid && mine_ff && !i_rx_start;
   assign long_cmd = (cmd_ff == CMD_OTP) || (cmd_ff == CMD_SETPOS) ||
                     (cmd_ff == CMD_REF) || (cmd_ff == CMD_MOTOR);

   // byte walker; a mismatch drops the rest of the frame
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_ff <= IDX_ADDR;
         mine_ff <= 1'b0;
         cmd_ff <= 8'h00;
         hold_ff <= 8'h00;
         otp_word_addr_ff <= 3'h0;
         pat_ff <= 8'h00;
         pos1_ff <= 16'h0000;
         tgt_ff <= 16'h0000;
         {ex_otp_ff, ex_pos_ff, ex_ref_ff, ex_soft_ff} <= 4'h0;
         {ex_hard_ff, ex_st1_ff, ex_st2_ff, bad_frame_ff} <= 4'h0;
      end
      else
      begin
         {ex_otp_ff, ex_pos_ff, ex_ref_ff, ex_soft_ff} <= 4'h0;
         {ex_hard_ff, ex_st1_ff, ex_st2_ff, bad_frame_ff} <= 4'h0;
         if (i_rx_start)
         begin
            idx_ff <= IDX_ADDR;
            mine_ff <= 1'b1;
         end
         else if (take)
         begin
            if (idx_ff != IDX_MAX)
               idx_ff <= idx_ff + 4'h1;
            hold_ff <= i_rx_byte;
            case (idx_ff)
               IDX_ADDR:
               begin
                  // frames for other nodes are silently skipped
                  if (i_rx_byte != own_addr(node_addr_ff, hw_bit))
                     mine_ff <= 1'b0;
               end
               IDX_CMD:
               begin
                  cmd_ff <= i_rx_byte;
                  ex_soft_ff <= (i_rx_byte == CMD_SOFT);
                  ex_hard_ff <= (i_rx_byte == CMD_HARD);
                  ex_st1_ff <= (i_rx_byte == CMD_STAT1);
                  ex_st2_ff <= (i_rx_byte == CMD_STAT2);
               end
               IDX_FILL_A, IDX_FILL_B:
               begin
                  // fillers must be all ones
                  if (long_cmd && i_rx_byte != FILL_BYTE)
                  begin
                     mine_ff <= 1'b0;
                     bad_frame_ff <= 1'b1;
                  end
               end
               IDX_P0:
               begin
                  if (cmd_ff == CMD_OTP)
                  begin
                     if (i_rx_byte[7:3] != OTP_WORD_ADDR_PREFIX)
                     begin
                        mine_ff <= 1'b0;
                        bad_frame_ff <= 1'b1;
                     end
                     otp_word_addr_ff <= i_rx_byte[2:0];
                  end
               end
               IDX_P1:
               begin
                  pat_ff <= i_rx_byte;
                  ex_otp_ff <= (cmd_ff == CMD_OTP);
                  // high byte arrived first
                  tgt_ff <= {hold_ff, i_rx_byte};
                  ex_pos_ff <= (cmd_ff == CMD_SETPOS);
               end
               IDX_P2:
                  pos1_ff <= {hold_ff, i_rx_byte};
               IDX_P4:
               begin
                  tgt_ff <= {hold_ff, i_rx_byte};
                  ex_ref_ff <= (cmd_ff == CMD_REF);
               end
               default:
                  ;  // other bytes only pass through hold_ff; P3 is the high half of the second target
            endcase
         end
      end
   end

   // ==============================================================
   // otp parameter memory
   logic [7:0] otp_mem [0:7];  // eight otp words

   // bits only ever go from zero to one
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int w = 0; w < 8; w++)
            otp_mem[w] <= OTP_RST;
      end
      else if (ex_otp_ff)
         otp_mem[otp_word_addr_ff] <= otp_mem[otp_word_addr_ff] | pat_ff;
   end

   // defaults presented from otp word 3
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         {o_run_current_dflt, o_hold_current_dflt} <= OTP_RST;
      else
         {o_run_current_dflt, o_hold_current_dflt} <= otp_mem[OTP_CUR_WORD];
   end

   // ==============================================================
   // power-on shutdown and deadlock
   logic deadlock_ff;  // motion locked out
   logic hard_seen_ff;  // hard stop seen while deadlocked
   logic may_move;  // motion commands accepted
   logic ref_bad;  // reference targets would deadlock
   assign may_move = !o_shutdown && !deadlock_ff;
   assign ref_bad = (pos1_ff == i_actual_pos) || (pos1_ff == tgt_ff);

   // shutdown is left by the first status read one
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         o_shutdown <= 1'b1;
      else if (ex_st1_ff)
         o_shutdown <= 1'b0;
   end

   // only hard stop directly followed by status read one unlocks
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         deadlock_ff <= 1'b0;
         hard_seen_ff <= 1'b0;
      end
      else if (ex_ref_ff && may_move && ref_bad)
         deadlock_ff <= 1'b1;
      else if (ex_hard_ff)
         hard_seen_ff <= deadlock_ff;
      else if (ex_st1_ff)
      begin
         if (hard_seen_ff)
            deadlock_ff <= 1'b0;
         hard_seen_ff <= 1'b0;
      end
      else if (ex_otp_ff || ex_pos_ff || ex_ref_ff || ex_soft_ff || ex_st2_ff)
         hard_seen_ff <= 1'b0;
   end

   // ==============================================================
   // motion requests and reference search
   mcd_ref_t ref_ff;  // reference search phase
   logic pos_ok;  // set-position may run
   logic refused;  // a motion command was dropped
   assign pos_ok = ex_pos_ff && may_move && !fault && ref_ff == REF_IDLE;
   assign refused = (ex_pos_ff && !pos_ok) ||
                    (ex_ref_ff && (!may_move || fault || ref_bad));

   // move requests; the search cannot be cut short except by hard stop or fault
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_ff <= REF_IDLE;
         o_move_go <= 1'b0;
         o_target_position <= 16'h0000;
         o_pos_zero <= 1'b0;
      end
      else
      begin
         o_move_go <= 1'b0;
         o_pos_zero <= 1'b0;
         case (ref_ff)
            REF_IDLE:
            begin
               if (pos_ok)
               begin
                  o_move_go <= 1'b1;
                  o_target_position <= tgt_ff;
               end
               else if (ex_ref_ff && may_move && !fault && !ref_bad)
               begin
                  o_move_go <= 1'b1;
                  o_target_position <= pos1_ff;
                  ref_ff <= REF_FIRST;
               end
            end
            REF_FIRST:
            begin
               if (ex_hard_ff || fault)
                  ref_ff <= REF_IDLE;
               else if (i_motion_done)
               begin
                  o_move_go <= 1'b1;
                  o_target_position <= tgt_ff;
                  ref_ff <= REF_SECOND;
               end
            end
            REF_SECOND:
            begin
               if (ex_hard_ff || fault)
                  ref_ff <= REF_IDLE;
               else if (i_motion_done)
               begin
                  o_pos_zero <= 1'b1;
                  ref_ff <= REF_IDLE;
               end
            end
            default:
               ref_ff <= REF_IDLE;
         endcase
      end
   end

   // ==============================================================
   // stops and status reports
   logic soft_req;  // soft stop wanted during a motion
   assign soft_req = i_motion_active && (ex_soft_ff || therm_rise);

   // stop requests and report strobes to the neighbours
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_soft_stop <= 1'b0;
         o_hard_stop <= 1'b0;
         o_report_one <= 1'b0;
         o_report_two <= 1'b0;
      end
      else
      begin
         o_soft_stop <= soft_req;
         o_hard_stop <= ex_hard_ff;
         o_report_one <= ex_st1_ff;
         o_report_two <= ex_st2_ff;
      end
   end

   // ==============================================================
   // register port and interrupt
   logic [IRQ_N-1:0] irq_stat_ff, irq_en_ff, ev;  // sticky, enable, events
   assign ev = {bad_frame_ff, ex_ref_ff && may_move && ref_bad, o_pos_zero,
                soft_req, refused, o_move_go, ex_otp_ff};

   // control and enable registers
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         node_addr_ff <= CTRL_RST;
         irq_en_ff <= IRQ_RST;
      end
      else if (i_reg_wr && i_reg_addr == OFF_CTRL)
         node_addr_ff <= i_reg_wdata[3:0];
      else if (i_reg_wr && i_reg_addr == OFF_IRQ_EN)
         irq_en_ff <= i_reg_wdata[IRQ_N-1:0];
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_ff <= IRQ_RST;
      else if (i_reg_wr && i_reg_addr == OFF_IRQ_CLR)
         irq_stat_ff <= (irq_stat_ff & ~i_reg_wdata[IRQ_N-1:0]) | ev;
      else
         irq_stat_ff <= irq_stat_ff | ev;
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_reg_rdata <= 32'h0000_0000;
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= |(irq_stat_ff & irq_en_ff);
         o_reg_rdata <= 32'h0000_0000;
         if (i_reg_rd)
            case (i_reg_addr)
               OFF_CTRL: o_reg_rdata <= {28'h0, node_addr_ff};
               OFF_STATE: o_reg_rdata <= {25'h0, ref_ff, hard_seen_ff,
                                          deadlock_ff, o_shutdown, fault, hw_bit};
               OFF_IRQ_STAT: o_reg_rdata <= {25'h0, irq_stat_ff};
               OFF_IRQ_EN: o_reg_rdata <= {25'h0, irq_en_ff};
               OFF_POS: o_reg_rdata <= {o_target_position, i_actual_pos};
               OFF_PROGRAMMED_ADDRESS_BIT: o_reg_rdata <= {24'h0, otp_mem[OTP_CUR_WORD]};
               default: o_reg_rdata <= 32'h0000_0000;  // unmapped reads zero
            endcase
      end
   end

   // ==============================================================
   // checks
   default clocking @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   property p_otp_burn;
      ex_otp_ff |=> otp_mem[$past(otp_word_addr_ff)] == ($past(otp_mem[otp_word_addr_ff]) | $past(pat_ff));
   endproperty
   a_otp_burn: assert property (p_otp_burn) else $error("otp burn wrong");

   property p_otp_keep;
      ##1 ($past(otp_mem[OTP_CUR_WORD]) & ~otp_mem[OTP_CUR_WORD]) == 8'h00;
   endproperty
   a_otp_keep: assert property (p_otp_keep) else $error("otp bit cleared");

   property p_dflt;
      ##1 {o_run_current_dflt, o_hold_current_dflt} == $past(otp_mem[OTP_CUR_WORD]);
   endproperty
   a_dflt: assert property (p_dflt) else $error("current defaults wrong");

   property p_setpos;
      pos_ok |=> o_move_go && o_target_position == $past(tgt_ff);
   endproperty
   a_setpos: assert property (p_setpos) else $error("set position lost");

   property p_fault_block;
      ex_pos_ff && fault && ref_ff == REF_IDLE |=> !o_move_go;
   endproperty
   a_fault_block: assert property (p_fault_block) else $error("move despite fault");

   property p_soft;
      i_motion_active && therm_rise |=> o_soft_stop;
   endproperty
   a_soft: assert property (p_soft) else $error("no soft stop");

   property p_shut;
      o_shutdown && !ex_st1_ff |=> o_shutdown && !o_move_go;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown left early");

   sequence s_ref_second;
      ref_ff == REF_SECOND && i_motion_done && !ex_hard_ff && !fault;
   endsequence
   property p_zero;
      s_ref_second |=> o_pos_zero && ref_ff == REF_IDLE;
   endproperty
   a_zero: assert property (p_zero) else $error("position not zeroed");

   // status read one that directly follows a hard stop while locked
   sequence s_unlock;
      ex_st1_ff && hard_seen_ff;
   endsequence
   property p_lock;
      deadlock_ff && !hard_seen_ff |=> deadlock_ff;
   endproperty
   a_lock: assert property (p_lock) else $error("deadlock left early");

   property p_unlock;
      s_unlock |=> !deadlock_ff;
   endproperty
   a_unlock: assert property (p_unlock) else $error("deadlock not left");

   property p_irq;
      ##1 o_irq == $past(|(irq_stat_ff & irq_en_ff));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output wrong");
endmodule

// File: mcd_host_model.sv
// host-side frame sender feeding received bytes to the decoder
`timescale 1ns/100ps
module mcd_host_model
(
   input wire logic i_clk,
   output logic o_rx_start,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte
);
   // ==============================================================
   // idle line: no frame, byte lines carry junk
   initial
   begin
      o_rx_start = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_byte = 8'hA5;
   end
   // one frame: start pulse, then address, command, payload
   // gap > 0 is a slow host; the idle byte line shows the inverse, never a stale copy
   task automatic send(input logic [7:0] fb[$], input int gap);
      o_rx_start <= 1'b1;
      @(posedge i_clk);
      o_rx_start <= 1'b0;
      foreach (fb[i])
      begin
         o_rx_valid <= 1'b1;
         o_rx_byte <= fb[i];
         @(posedge i_clk);
         if (gap > 0)
         begin
            o_rx_valid <= 1'b0;
            o_rx_byte <= ~fb[i];
            repeat (gap) @(posedge i_clk);
         end
      end
      o_rx_valid <= 1'b0;
      o_rx_byte <= ~fb[fb.size()-1];
   endtask
endmodule

// File: mcd_decoder_bench.sv
// self-checking bench for the motor command decoder
`timescale 1ns/100ps
module mcd_decoder_bench;
   import mcd_pkg::*;
   // ==============================================================
   // stimulus, set at time zero
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_motion_active = 1'b0, i_motion_done = 1'b0, i_hw_address_pin_bit = 1'b1;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic [15:0] i_actual_pos = 16'h0;
   logic [3:0] flt = 4'h0;
   // design outputs and host-model wires
   logic i_rx_start, i_rx_valid, o_irq, o_move_go, o_soft_stop, o_hard_stop;
   logic o_pos_zero, o_report_one, o_report_two, o_shutdown;
   logic [7:0] i_rx_byte, ab, otp_exp;
   logic [31:0] o_reg_rdata;
   logic [15:0] o_target_position, p;
   logic [3:0] node, o_run_current_dflt, o_hold_current_dflt;
   logic [7:0] q[$];
   int n_go = 0, n_soft = 0, n_zero = 0, n_r1 = 0, n_r2 = 0, n_hard = 0, b;
   int miscompares = 0, comparisons = 0;
   int seed = 32'h9FE7CE4C;
   always #5 i_clk = ~i_clk;
   // ==============================================================
   mcd_host_model u_host
   (
      .i_clk, .o_rx_start(i_rx_start), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte)
   );
   mcd_decoder u_dut
   (
      .i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .o_irq, .i_rx_start, .i_rx_valid, .i_rx_byte, .i_hw_address_pin_bit,
      .i_thermal_shutdown_flag(flt[0]), .i_undervoltage_flag(flt[1]),
      .i_step_loss_flag(flt[2]), .i_electrical_defect_flag(flt[3]),
      .i_motion_active, .i_motion_done, .i_actual_pos, .o_move_go, .o_target_position,
      .o_soft_stop, .o_hard_stop, .o_pos_zero, .o_report_one, .o_report_two,
      .o_shutdown, .o_run_current_dflt, .o_hold_current_dflt
   );
   // count command pulses, so checks need not land on the pulse cycle
   always @(posedge i_clk)
   begin
      n_go <= n_go + int'(o_move_go === 1'b1);
      n_soft <= n_soft + int'(o_soft_stop === 1'b1);
      n_zero <= n_zero + int'(o_pos_zero === 1'b1);
      n_r1 <= n_r1 + int'(o_report_one === 1'b1);
      n_r2 <= n_r2 + int'(o_report_two === 1'b1);
      n_hard <= n_hard + int'(o_hard_stop === 1'b1);
   end
   // ==============================================================
   // expectations
   function automatic logic [7:0] otp_next(input logic [7:0] old, input logic [7:0] pat);
      return old | pat;
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   // register port: every task starts and ends just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      chk("register read", e, o_reg_rdata & m);
      @(posedge i_clk);
   endtask
   // frame = address byte, command, queued payload; random host pacing
   task automatic fr(input logic [7:0] cmd);
      q.push_front(cmd);
      q.push_front(ab);
      u_host.send(q, $random(seed) & 1);
      q = {};
      // pulses land two edges after the last byte; the counters one edge later
      repeat (4) @(posedge i_clk);
   endtask
   task automatic setpos(input logic [15:0] t);
      q = '{FILL_BYTE, FILL_BYTE, t[15:8], t[7:0]};
      fr(CMD_SETPOS);
   endtask
   task automatic mdone;
      i_motion_done <= 1'b1;
      @(posedge i_clk);
      i_motion_done <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      $display("BAD watchdog expected finish seen hang");
      final_report;
   end
   // ==============================================================
   initial
   begin
      node = 4'($random(seed));
      ab = {ADDR_PREFIX, node, 1'b1, 1'b0};
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk("shutdown", 32'h1, 32'(o_shutdown));
      wr(OFF_CTRL, 32'(node));
      rdchk(OFF_CTRL, 32'hF, 32'(node));
      wr(OFF_IRQ_EN, 32'h2);
      rdchk(8'h1C, 32'hFFFFFFFF, 32'h0);
      setpos(16'h1234);
      chk("moves", 32'h0, n_go);
      rdchk(OFF_IRQ_STAT, 32'h4, 32'h4);
      fr(CMD_STAT1);
      chk("shutdown", 32'h0, 32'(o_shutdown));
      fr(CMD_STAT2);
      chk("status reports", 32'h2, n_r1 + n_r2);
      q = '{FILL_BYTE, FILL_BYTE, 8'hDA, 8'h7C, 8'h0F, 8'h10, 8'hFF};
      fr(CMD_MOTOR);
      $display("test power-on order done");
      // first target on the actual position locks the search
      i_actual_pos <= 16'($random(seed));
      @(posedge i_clk);
      q = '{FILL_BYTE, FILL_BYTE, 8'h55, i_actual_pos[15:8], i_actual_pos[7:0], 8'h00, 8'h01};
      fr(CMD_REF);
      rdchk(OFF_STATE, 32'h8, 32'h8);
      fr(CMD_HARD);
      chk("hard stops", 32'h1, n_hard);
      fr(CMD_STAT1);
      rdchk(OFF_STATE, 32'h8, 32'h0);
      p = ~i_actual_pos;
      q = '{FILL_BYTE, FILL_BYTE, 8'h55, p[15:8], p[7:0], p[15:8], ~p[7:0]};
      fr(CMD_REF);
      chk("first target", 32'(p), 32'(o_target_position));
      mdone();
      chk("second target", 32'({p[15:8], ~p[7:0]}), 32'(o_target_position));
      mdone();
      chk("zeroing", 32'h1, n_zero);
      $display("test reference search done");
      for (b = 0; b < 4; b++)
      begin
         p = (b == 0) ? 16'hFFFF : 16'($random(seed));
         setpos(p);
         chk("target", 32'(p), 32'(o_target_position));
      end
      chk("moves", 32'h6, n_go);
      chk("irq raised", 32'h1, 32'(o_irq));
      wr(OFF_IRQ_EN, 32'h0);
      rdchk(OFF_IRQ_STAT, 32'h2, 32'h2);
      chk("irq masked", 32'h0, 32'(o_irq));
      wr(OFF_IRQ_CLR, 32'h7F);
      rdchk(OFF_IRQ_STAT, 32'h7F, 32'h0);
      for (b = 0; b < 4; b++)
      begin
         flt <= 4'(1 << b);
         repeat (4) @(posedge i_clk);
         setpos(16'h0100);
         chk("refused moves", 32'h6, n_go);
      end
      flt <= 4'h0;
      // address pin low: a frame for pin high is foreign, one for pin low is ours
      i_hw_address_pin_bit <= 1'b0;
      repeat (4) @(posedge i_clk);
      setpos(16'h0200);
      chk("foreign node", 32'h6, n_go);
      ab[1] = 1'b0;
      setpos(16'h0300);
      chk("pin node", 32'h7, n_go);
      i_motion_active <= 1'b1;
      repeat (4) @(posedge i_clk);
      fr(CMD_SOFT);
      chk("soft stops", 32'h1, n_soft);
      flt <= 4'h1;
      repeat (5) @(posedge i_clk);
      chk("soft stops", 32'h2, n_soft);
      flt <= 4'h0;
      i_motion_active <= 1'b0;
      $display("test faults and stops done");
      q = '{FILL_BYTE, FILL_BYTE, 8'h03, 8'h50};
      fr(CMD_OTP);
      rdchk(OFF_IRQ_STAT, 32'h40, 32'h40);
      otp_exp = 8'h00;
      for (b = 0; b < 3; b++)
      begin
         p = 16'($random(seed));
         q = '{FILL_BYTE, FILL_BYTE, {OTP_WORD_ADDR_PREFIX, (b == 1) ? 3'h5 : OTP_CUR_WORD}, p[7:0]};
         fr(CMD_OTP);
         if (b != 1)
            otp_exp = otp_next(otp_exp, p[7:0]);
      end
      rdchk(OFF_PROGRAMMED_ADDRESS_BIT, 32'hFF, 32'(otp_exp));
      chk("run default", 32'(otp_exp[7:4]), 32'(o_run_current_dflt));
      chk("hold default", 32'(otp_exp[3:0]), 32'(o_hold_current_dflt));
      $display("test parameter memory done");
      final_report;
   end
endmodule
